// File: src/gsi_sequencer.sv
// Start termination, running detection and idle-run sequencing with a Wishbone slave.
//
// Contract
// - Crank-release speed level is software configurable.
// - Running at running threshold, default 1000 RPM.
// - Release start relay at crank threshold, 400.
// - Pickup speed uses configured tooth count.
// - Crank release from pickup speed or input.
// - Oil pressure above set value means running.
// - Separate start and stop idle timers, enables.
// - Idle select never blocks stopping.
// - Temperature hold starts and prevents stopping.
// - Timers in use override idle select.
// - One dedicated output commands governor idle.
// - Idle after start, idle before stop.
// - No timers: idle while select active.
// - Idle needs enable and assigned output.
// - Temperature mode idles while coolant cold.
// - Idle inhibits selected alarms, oil alarms stay.
// - Running stays asserted during idle.
// - Running drops the start relay.
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`include "gsi_cfg.svh"
`timescale 1ns/1ns
module gsi_sequencer import gsi_pkg::*; #(
  parameter int unsigned GATE_CYC = `GSI_GATE_CYC,
  parameter int unsigned TICK_CYC = `GSI_TICK_CYC,
  parameter int unsigned CNT_W    = 20
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Digital pins, asynchronous.
  input  wire logic        start_cmd_i,
  input  wire logic        stop_cmd_i,
  input  wire logic        run_feedback_i,
  input  wire logic        remove_starter_i,
  input  wire logic        low_speed_i,
  input  wire logic        temp_hold_i,
  input  wire logic        tooth_pulse_pickup_i,
  // Measurement results on the same clock.
  input  wire logic        freq_running_i,
  input  wire logic        engine_bus_interface_run_i,
  input  wire logic [43:0] resistive_sensor_input_i,
  input  wire logic        coolant_cold_i,
  input  wire logic [7:0]  alarm_raw_i,
  input  wire logic [3:0]  oil_alarm_raw_i,
  // Outputs to starter, governor, engine and alarm handling.
  output logic             start_relay_o,
  output logic             running_o,
  output logic             idle_cmd_o,
  output logic             run_request_o,
  output logic [7:0]       alarm_o,
  output logic [3:0]       oil_alarm_o
);

  // Speed test without a divider: pulses * 60 against rpm * teeth.
  function automatic logic speed_ge(input logic [CNT_W-1:0] cnt, input logic [11:0] rpm,
                                    input logic [8:0] teeth);
    logic [31:0] lhs;
    logic [31:0] rhs;
    lhs = 32'(cnt) * 32'(`GSI_RPM_PER_HZ);
    rhs = 32'(rpm) * 32'(teeth);
    return (teeth != 9'h0) && (lhs >= rhs);
  endfunction : speed_ge

  // Byte-lane merge of a write into an old register value.
  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] dat,
                                           input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction : wb_merge

  // Configuration registers.
  logic [10:0]      ctrl;
  logic [11:0]      run_rpm;
  logic [10:0]      crank_rpm;
  logic [8:0]       teeth;
  logic [10:0]      oil_set;
  logic [13:0]      start_tmr;
  logic [13:0]      stop_tmr;
  logic [7:0]       inh_mask;
  // Pin synchronisers and sequencer state.
  logic [5:0]       pin_s1;
  logic [5:0]       pin_s2;
  gsi_state_e       state;
  gsi_state_e       next_state;
  logic             crank_released;
  logic [CNT_W-1:0] pulses;
  logic             start_done;
  logic             stop_done;
  logic [31:0]      rd_mux;
  logic [10:0]      oil_val;
  logic             run_det;

  // Two flip-flops on every pin before any logic reads it.
  always_ff @(posedge clk_i) begin
    pin_s1 <= {temp_hold_i, start_cmd_i, stop_cmd_i, run_feedback_i, remove_starter_i,
               low_speed_i};
    pin_s2 <= pin_s1;
  end

  wire start_s   = pin_s2[4];
  wire stop_s    = pin_s2[3];
  wire runfb_s   = pin_s2[2];
  wire remove_s  = pin_s2[1];
  wire lowspd_s  = pin_s2[0];
  wire temp_s    = pin_s2[5];

  // Bus decode; one wait state, unmapped reads return zero and writes are dropped.
  wire wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr     = wb_req & wb_we_i;
  wire hit_ctrl  = (wb_adr_i == `GSI_OFF_CTRL);
  wire hit_run   = (wb_adr_i == `GSI_OFF_RUN_RPM);
  wire hit_crank = (wb_adr_i == `GSI_OFF_CRANK_RPM);
  wire hit_teeth = (wb_adr_i == `GSI_OFF_TEETH);
  wire hit_oil   = (wb_adr_i == `GSI_OFF_OIL_SET);
  wire hit_stt   = (wb_adr_i == `GSI_OFF_START_TMR);
  wire hit_spt   = (wb_adr_i == `GSI_OFF_STOP_TMR);
  wire hit_inh   = (wb_adr_i == `GSI_OFF_INH_MASK);
  // The read mux already holds the addressed register, so one merge serves every write.
  wire [31:0] wr_word = wb_merge(rd_mux, wb_dat_i, wb_sel_i);

  // Register writes; each field keeps only its own width.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl      <= `GSI_RST_CTRL;
      run_rpm   <= `GSI_RST_RUN_RPM;
      crank_rpm <= `GSI_RST_CRANK_RPM;
      teeth     <= `GSI_RST_TEETH;
      oil_set   <= `GSI_RST_OIL_SET;
      start_tmr <= `GSI_RST_TMR;
      stop_tmr  <= `GSI_RST_TMR;
      inh_mask  <= `GSI_RST_INH_MASK;
    end else if (wb_wr) begin
      if (hit_ctrl)  ctrl      <= wr_word[10:0];
      if (hit_run)   run_rpm   <= wr_word[11:0];
      if (hit_crank) crank_rpm <= wr_word[10:0];
      if (hit_teeth) teeth     <= wr_word[8:0];
      if (hit_oil)   oil_set   <= wr_word[10:0];
      if (hit_stt)   start_tmr <= wr_word[13:0];
      if (hit_spt)   stop_tmr  <= wr_word[13:0];
      if (hit_inh)   inh_mask  <= wr_word[7:0];
    end
  end

  // Control fields.
  wire       idle_en    = ctrl[`GSI_CTRL_IDLE_EN];
  wire       start_en   = ctrl[`GSI_CTRL_START_EN];
  wire       stop_en    = ctrl[`GSI_CTRL_STOP_EN];
  wire       idle_out   = ctrl[`GSI_CTRL_IDLE_OUT];
  wire       temp_mode  = ctrl[`GSI_CTRL_TEMP_MODE];
  wire       crank_di   = ctrl[`GSI_CTRL_CRANK_DI];
  wire [2:0] run_src    = ctrl[`GSI_CTRL_SRC_LO +: 3];
  wire [1:0] oil_idx    = ctrl[`GSI_CTRL_OIL_LO +: 2];

  // Read data selection, including live state and measured pulses.
  always_comb begin
    case (wb_adr_i)
      `GSI_OFF_CTRL:      rd_mux = 32'(ctrl);
      `GSI_OFF_RUN_RPM:   rd_mux = 32'(run_rpm);
      `GSI_OFF_CRANK_RPM: rd_mux = 32'(crank_rpm);
      `GSI_OFF_TEETH:     rd_mux = 32'(teeth);
      `GSI_OFF_OIL_SET:   rd_mux = 32'(oil_set);
      `GSI_OFF_START_TMR: rd_mux = 32'(start_tmr);
      `GSI_OFF_STOP_TMR:  rd_mux = 32'(stop_tmr);
      `GSI_OFF_INH_MASK:  rd_mux = 32'(inh_mask);
      `GSI_OFF_STATUS:    rd_mux = {24'h0, state, idle_cmd_o, running_o, start_relay_o,
                                    run_request_o, crank_released};
      `GSI_OFF_SPEED:     rd_mux = 32'(pulses);
      default:            rd_mux = 32'h0;
    endcase
  end

  // Acknowledge one cycle after the request; ack drops in the following cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : 32'h0;
    end
  end

  // Pickup speed measurement; the meter brings the pin into this clock itself.
  gsi_speed_meter #(
    .GATE_CYC (GATE_CYC),
    .CNT_W    (CNT_W)
  ) u_speed (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .tooth_pulse_pickup_i (tooth_pulse_pickup_i),
    .pulses_o             (pulses)
  );

  // Oil pressure of the chosen multi-input, in tenths.
  always_comb begin
    case (oil_idx)
      2'h0:    oil_val = resistive_sensor_input_i[10:0];
      2'h1:    oil_val = resistive_sensor_input_i[21:11];
      2'h2:    oil_val = resistive_sensor_input_i[32:22];
      default: oil_val = resistive_sensor_input_i[43:33];
    endcase
  end

  // Running detection from exactly one source; unknown codes never report running.
  always_comb begin
    case (run_src)
      GSI_SRC_DI:     run_det = runfb_s;
      GSI_SRC_PICKUP: run_det = speed_ge(pulses, run_rpm, teeth);
      GSI_SRC_FREQ:   run_det = freq_running_i;
      GSI_SRC_ENGBUS: run_det = engine_bus_interface_run_i;
      GSI_SRC_OIL:    run_det = (oil_val > oil_set);
      default:        run_det = 1'b0;
    endcase
  end

  // Crank release from speed or the remove-starter input.
  wire crank_spd  = speed_ge(pulses, {1'b0, crank_rpm}, teeth);
  wire crank_ev   = crank_di ? remove_s : crank_spd;

  // Idle-run qualification; an enabled timer overrides the select input.
  wire idle_ok    = idle_en & idle_out;
  wire timers_off = ~start_en & ~stop_en;
  wire sel_idle   = (timers_off & lowspd_s) | (temp_mode & coolant_cold_i);
  wire start_req  = start_s | temp_s;
  // Only the stop command and the hold input decide stopping, never the idle select.
  wire stop_req   = stop_s & ~temp_s;

  // Next state of the sequence.
  always_comb begin
    next_state = state;
    case (state)
      GSI_STOPPED: begin
        if (start_req && !stop_req) next_state = GSI_CRANK;
      end
      GSI_CRANK: begin
        if (stop_req) begin
          next_state = GSI_STOPPED;
        end else if (run_det) begin
          next_state = (idle_ok && start_en) ? GSI_IDLE_START : GSI_RUN;
        end
      end
      GSI_IDLE_START: begin
        if (stop_req) begin
          next_state = (idle_ok && stop_en) ? GSI_IDLE_STOP : GSI_STOPPED;
        end else if (start_done) begin
          next_state = GSI_RUN;
        end
      end
      GSI_RUN: begin
        if (stop_req) begin
          next_state = (idle_ok && stop_en) ? GSI_IDLE_STOP : GSI_STOPPED;
        end
      end
      GSI_IDLE_STOP: begin
        // The hold input keeps the set in idle past the stop delay.
        if (stop_done && !temp_s) next_state = GSI_STOPPED;
      end
      default: next_state = GSI_STOPPED;
    endcase
  end

  // Independent start and stop idle timers.
  gsi_min_timer #(.TICK_CYC (TICK_CYC)) u_start_tmr (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .en_i     (state == GSI_IDLE_START),
    .preset_i (start_tmr),
    .done_o   (start_done)
  );

  gsi_min_timer #(.TICK_CYC (TICK_CYC)) u_stop_tmr (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .en_i     (state == GSI_IDLE_STOP),
    .preset_i (stop_tmr),
    .done_o   (stop_done)
  );

  // Derived output levels.
  wire in_idle_st = (next_state == GSI_IDLE_START) || (next_state == GSI_IDLE_STOP);
  wire next_idle  = idle_ok && (in_idle_st || (next_state == GSI_RUN && sel_idle));
  wire next_run   = (next_state != GSI_STOPPED) && (next_state != GSI_CRANK);
  // A fresh crank clears the release memory so the starter engages again.
  wire next_rel   = (next_state == GSI_CRANK) && (crank_released || crank_ev);

  // Sequencer register and outputs, all taken straight from flip-flops.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state          <= GSI_STOPPED;
      crank_released <= 1'b0;
      start_relay_o  <= 1'b0;
      running_o      <= 1'b0;
      idle_cmd_o     <= 1'b0;
      run_request_o  <= 1'b0;
      alarm_o        <= 8'h00;
      oil_alarm_o    <= 4'h0;
    end else begin
      state          <= next_state;
      crank_released <= next_rel;
      start_relay_o  <= (next_state == GSI_CRANK) && !next_rel && !run_det;
      running_o      <= run_det || next_run;
      idle_cmd_o     <= next_idle;
      run_request_o  <= (next_state != GSI_STOPPED);
      alarm_o        <= alarm_raw_i & ~(inh_mask & {8{next_idle}});
      oil_alarm_o    <= oil_alarm_raw_i;
    end
  end

endmodule : gsi_sequencer

// File: src/gsi_cfg.svh
// Register offsets, field positions, reset values and timing counts of the sequencer.
`ifndef GSI_CFG_SVH
`define GSI_CFG_SVH

// Word-aligned byte offsets on the register bus.
`define GSI_OFF_CTRL      8'h00
`define GSI_OFF_RUN_RPM   8'h04
`define GSI_OFF_CRANK_RPM 8'h08
`define GSI_OFF_TEETH     8'h0c
`define GSI_OFF_OIL_SET   8'h10
`define GSI_OFF_START_TMR 8'h14
`define GSI_OFF_STOP_TMR  8'h18
`define GSI_OFF_INH_MASK  8'h1c
`define GSI_OFF_STATUS    8'h20
`define GSI_OFF_SPEED     8'h24

// Control register field positions.
`define GSI_CTRL_IDLE_EN   0
`define GSI_CTRL_START_EN  1
`define GSI_CTRL_STOP_EN   2
`define GSI_CTRL_IDLE_OUT  3
`define GSI_CTRL_TEMP_MODE 4
`define GSI_CTRL_CRANK_DI  5
`define GSI_CTRL_SRC_LO    6
`define GSI_CTRL_OIL_LO    9

// Reset values: run source frequency, speeds in RPM, times in tenths of a minute.
`define GSI_RST_CTRL      11'h080
`define GSI_RST_RUN_RPM   12'h3e8
`define GSI_RST_CRANK_RPM 11'h190
`define GSI_RST_TEETH     9'h000
`define GSI_RST_OIL_SET   11'h000
`define GSI_RST_TMR       14'hbb8
`define GSI_RST_INH_MASK  8'h00

// Timing: clock rate, speed gate window and timer tick of 0.1 min.
`define GSI_CLK_KHZ      250000
`define GSI_GATE_MS      1000
`define GSI_TICK_MS      6000
`define GSI_GATE_CYC     (`GSI_GATE_MS * `GSI_CLK_KHZ)
`define GSI_TICK_CYC     (`GSI_TICK_MS * `GSI_CLK_KHZ)
`define GSI_RPM_PER_HZ   60

`endif

// File: src/gsi_pkg.sv
// Types shared by the start and idle sequencer modules.
package gsi_pkg;

  // Sequencer states.
  typedef enum logic [2:0] {
    GSI_STOPPED,
    GSI_CRANK,
    GSI_IDLE_START,
    GSI_RUN,
    GSI_IDLE_STOP
  } gsi_state_e;

  // Running-detection source codes as held in the control register.
  typedef enum logic [2:0] {
    GSI_SRC_DI     = 3'h0,
    GSI_SRC_PICKUP = 3'h1,
    GSI_SRC_FREQ   = 3'h2,
    GSI_SRC_ENGBUS = 3'h3,
    GSI_SRC_OIL    = 3'h4
  } gsi_run_src_e;

endpackage : gsi_pkg

// File: src/gsi_speed_meter.sv
// Counts tooth pulses of the pickup over a fixed gate window.
`timescale 1ns/1ns
module gsi_speed_meter #(
  parameter int unsigned GATE_CYC = 250000000,
  parameter int unsigned CNT_W    = 20
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Raw pickup pin.
  input  wire logic             tooth_pulse_pickup_i,
  // Pulses counted in the last complete window.
  output logic [CNT_W-1:0]      pulses_o
);

  logic             sync1;
  logic             sync2;
  logic             prev;
  logic [31:0]      gate;
  logic [CNT_W-1:0] acc;
  wire              rise = sync2 & ~prev;
  wire              gate_end = (gate == GATE_CYC - 1);

  // The pin is asynchronous, so only the second stage feeds the edge detector.
  always_ff @(posedge clk_i) begin
    sync1 <= tooth_pulse_pickup_i;
    sync2 <= sync1;
    prev  <= sync2;
  end

  // Gate window; the count saturates rather than wrapping at very high rates.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate     <= 32'h0;
      acc      <= '0;
      pulses_o <= '0;
    end else if (gate_end) begin
      gate     <= 32'h0;
      pulses_o <= acc;
      acc      <= {{(CNT_W-1){1'b0}}, rise};
    end else begin
      gate <= gate + 32'h1;
      if (rise && acc != {CNT_W{1'b1}}) begin
        acc <= acc + 1'b1;
      end
    end
  end

endmodule : gsi_speed_meter

// File: src/gsi_min_timer.sv
// Down counter in tenths of a minute, running while its enable is high.
`timescale 1ns/1ns
module gsi_min_timer #(
  parameter int unsigned TICK_CYC = 1500000000
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Run enable and preset in tenths of a minute.
  input  wire logic        en_i,
  input  wire logic [13:0] preset_i,
  // High once the preset time has elapsed, until the enable falls.
  output logic             done_o
);

  logic [30:0] tick;
  logic [13:0] remain;
  wire         tick_end = (tick == 31'(TICK_CYC - 1));

  // Dropping the enable reloads the preset, so each use starts a fresh delay.
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      tick   <= 31'h0;
      remain <= preset_i;
      done_o <= 1'b0;
    end else if (remain == 14'h0) begin
      done_o <= 1'b1;
    end else if (tick_end) begin
      tick   <= 31'h0;
      remain <= remain - 14'h1;
    end else begin
      tick <= tick + 31'h1;
    end
  end

endmodule : gsi_min_timer

// File: test/gsi_seq_assertions.sv
// Port-level checks for the start and idle sequencer.
`timescale 1ns/1ns
module gsi_seq_assertions (
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus handshake.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Pins, alarms and engine outputs.
  input wire logic        temp_hold_i,
  input wire logic [7:0]  alarm_raw_i,
  input wire logic [3:0]  oil_alarm_raw_i,
  input wire logic        start_relay_o,
  input wire logic        running_o,
  input wire logic        idle_cmd_o,
  input wire logic        run_request_o,
  input wire logic [7:0]  alarm_o,
  input wire logic [3:0]  oil_alarm_o
);
  // One clock domain, so reset silences every check.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Starter, running and idle relations.
  a_relay_drop_run: assert property (running_o |-> !start_relay_o)
    else $error("start relay on while running");
  a_idle_is_run: assert property (idle_cmd_o |-> running_o)
    else $error("idle commanded without running state");
  a_crank_entry: assert property ($rose(start_relay_o) |-> $rose(run_request_o))
    else $error("start relay rose outside a fresh start");
  // A held hold input must keep the set running whatever stop does.
  a_hold_keeps_req: assert property (temp_hold_i [*5] ##0 run_request_o |=> run_request_o)
    else $error("run request dropped under temperature hold");

  // Alarm routing: oil alarms never inhibited, nothing invented.
  a_oil_alarm_kept: assert property (!$past(rst_i) && !$past(rst_i, 2)
    |-> oil_alarm_o == $past(oil_alarm_raw_i))
    else $error("oil alarm not passed through");
  a_alarm_no_new: assert property (!$past(rst_i) |-> (alarm_o & ~$past(alarm_raw_i)) == 8'h00)
    else $error("alarm raised with no raw cause");
  a_alarm_pass: assert property (!idle_cmd_o && !$past(idle_cmd_o) && !$past(rst_i)
    |-> alarm_o == $past(alarm_raw_i))
    else $error("alarm masked outside idle");

  // Bus answer timing.
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack cycle");

  // Main scenarios reached.
  c_release: cover property ($fell(start_relay_o) && !running_o);
  c_idle: cover property ($rose(idle_cmd_o));
  c_stop: cover property ($fell(run_request_o));
endmodule : gsi_seq_assertions

bind gsi_sequencer gsi_seq_assertions CHK (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .wb_dat_o, .temp_hold_i, .alarm_raw_i, .oil_alarm_raw_i, .start_relay_o, .running_o,
  .idle_cmd_o, .run_request_o, .alarm_o, .oil_alarm_o);

// File: test/gsi_engine_model.sv
// Engine, starter and governor stand-in that sends pickup teeth back.
`timescale 1ns/1ns
module gsi_engine_model (
  // Clock.
  input  wire logic       clk_i,
  // Commands from the sequencer and the bench.
  input  wire logic       run_request_i,
  input  wire logic       idle_cmd_i,
  input  wire logic       fb_en_i,
  input  wire logic [7:0] period_i,
  // Sensor lines back.
  output logic            tooth_pulse_pickup_o,
  output logic            run_feedback_o
);
  logic [8:0] cnt;
  logic [8:0] span;

  // The governor halves the tooth rate at idle; a still shaft sends none.
  assign span = idle_cmd_i ? {period_i, 1'b0} : {1'b0, period_i};
  assign tooth_pulse_pickup_o = run_request_i && (cnt < span[8:1]);
  assign run_feedback_o = fb_en_i && run_request_i;

  // Tooth phase counter.
  always_ff @(posedge clk_i) begin
    cnt <= (!run_request_i || cnt + 9'h001 >= span) ? 9'h000 : cnt + 9'h001;
  end
endmodule : gsi_engine_model

// File: test/testbench.sv
// Self-checking bench for the start and idle sequencer.
`timescale 1ns/1ns
module testbench;
  // Drives and observed outputs.
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = 8'h00, alarm_raw_i = 8'h00, period = 8'h19, alarm_o;
  logic [3:0]  wb_sel_i = 4'hf, oil_alarm_raw_i = 4'h0, oil_alarm_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  logic [43:0] oil_in = 44'h0;
  logic        start_cmd_i = 0, stop_cmd_i = 0, remove_starter_i = 0, low_speed_i = 0;
  logic        temp_hold_i = 0, freq_running_i = 0, fb_en = 0, tooth, run_fb;
  logic        eng_run = 0, cold = 0;
  logic        wb_ack_o, start_relay_o, running_o, idle_cmd_o, run_request_o;
  int          bad_count = 0, num_checks = 0, cycles = 0;
  localparam int RLY = 0, RUN = 1, IDL = 2, REQ = 3;

  // Short gate and tick keep the run small: 1 gate = 250 cycles, 0.1 min = 10.
  gsi_sequencer #(.GATE_CYC(250), .TICK_CYC(10)) DUT (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .start_cmd_i, .stop_cmd_i, .run_feedback_i(run_fb), .remove_starter_i, .low_speed_i,
    .temp_hold_i, .tooth_pulse_pickup_i(tooth), .freq_running_i,
    .engine_bus_interface_run_i(eng_run), .resistive_sensor_input_i(oil_in),
    .coolant_cold_i(cold), .alarm_raw_i, .oil_alarm_raw_i, .start_relay_o, .running_o,
    .idle_cmd_o, .run_request_o, .alarm_o, .oil_alarm_o);
  gsi_engine_model ENG (.clk_i, .run_request_i(run_request_o), .idle_cmd_i(idle_cmd_o),
    .fb_en_i(fb_en), .period_i(period), .tooth_pulse_pickup_o(tooth), .run_feedback_o(run_fb));

  // Clock and hang guard.
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      conclude();
    end
  end

  task conclude();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %0t: got %h, expected %h", $time, s, e);
    end
  endtask : chk

  // Classic cycle: hold until ack is seen at an edge, then release for a cycle.
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_i);
  endtask : wb

  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task rc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rc

  // Waits, bounded, for one engine output to reach a level.
  task wt(input int w, input logic v);
    logic [3:0] s;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk_i);
      s = {run_request_o, idle_cmd_o, running_o, start_relay_o};
      if (s[w] === v) break;
    end
    chk(s[w], v);
  endtask : wt

  task rst();
    rst_i <= 1;
    {start_cmd_i, stop_cmd_i, remove_starter_i, low_speed_i, temp_hold_i} <= 5'h00;
    {freq_running_i, fb_en, eng_run, cold} <= 4'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    repeat (3) @(posedge clk_i);
  endtask : rst

  task t_regs();
    rc(8'h00, 32'h080);
    rc(8'h04, 32'h3e8);
    rc(8'h08, 32'h190);
    rc(8'h0c, 32'h000);
    rc(8'h14, 32'hbb8);
    rc(8'h18, 32'hbb8);
    wr(8'h08, 32'h7d0);
    rc(8'h08, 32'h7d0);
    wr(8'h3c, 32'hffffffff);
    rc(8'h3c, 32'h000);
  endtask : t_regs

  // One tooth per turn: 10 teeth a gate is 600 RPM, 25 is 1500 RPM.
  task t_pickup();
    rst();
    wr(8'h0c, 32'h001);
    wr(8'h00, 32'h040);
    period <= 8'h19;
    start_cmd_i <= 1;
    wt(RLY, 1);
    start_cmd_i <= 0;
    wt(RLY, 0);
    chk(running_o, 1'b0);
    period <= 8'h0a;
    wt(RUN, 1);
    rc(8'h20, 32'h06a);
  endtask : t_pickup

  // Zero teeth must never yield a speed, however fast the shaft turns.
  task t_noteeth();
    rst();
    wr(8'h00, 32'h040);
    period <= 8'h04;
    start_cmd_i <= 1;
    wt(RLY, 1);
    repeat (800) @(posedge clk_i);
    chk(start_relay_o, 1'b1);
  endtask : t_noteeth

  task t_oil();
    rst();
    wr(8'h10, 32'h032);
    wr(8'h00, 32'h300);
    oil_in[21:11] <= 11'h032;
    start_cmd_i <= 1;
    wt(RLY, 1);
    repeat (20) @(posedge clk_i);
    chk(running_o, 1'b0);
    oil_in[21:11] <= 11'h033;
    wt(RUN, 1);
    wt(RLY, 0);
  endtask : t_oil

  task t_remove();
    rst();
    wr(8'h00, 32'h020);
    start_cmd_i <= 1;
    wt(RLY, 1);
    remove_starter_i <= 1;
    wt(RLY, 0);
    chk(running_o, 1'b0);
  endtask : t_remove

  // Timers of 0.2 min each; the select input stays high to prove it is overruled.
  task t_idle_tmr();
    rst();
    wr(8'h14, 32'h002);
    wr(8'h18, 32'h002);
    wr(8'h00, 32'h08f);
    low_speed_i <= 1;
    start_cmd_i <= 1;
    freq_running_i <= 1;
    wt(IDL, 1);
    start_cmd_i <= 0;
    chk(running_o, 1'b1);
    repeat (15) @(posedge clk_i);
    chk(idle_cmd_o, 1'b1);
    wt(IDL, 0);
    stop_cmd_i <= 1;
    wt(IDL, 1);
    repeat (15) @(posedge clk_i);
    chk(run_request_o, 1'b1);
    wt(REQ, 0);
  endtask : t_idle_tmr

  task t_low_speed();
    rst();
    wr(8'h00, 32'h081);
    low_speed_i <= 1;
    start_cmd_i <= 1;
    freq_running_i <= 1;
    wt(RUN, 1);
    start_cmd_i <= 0;
    repeat (20) @(posedge clk_i);
    chk(idle_cmd_o, 1'b0);
    wr(8'h00, 32'h089);
    wt(IDL, 1);
    wr(8'h1c, 32'h00f);
    alarm_raw_i <= 8'hff;
    oil_alarm_raw_i <= 4'hf;
    repeat (3) @(posedge clk_i);
    chk(alarm_o, 8'hf0);
    chk(oil_alarm_o, 4'hf);
    low_speed_i <= 0;
    wt(IDL, 0);
    low_speed_i <= 1;
    wt(IDL, 1);
    stop_cmd_i <= 1;
    wt(REQ, 0);
  endtask : t_low_speed

  // Engine-bus running with a cold engine: idle until the coolant warms.
  task t_temp_mode();
    rst();
    wr(8'h00, 32'h0d9);
    {eng_run, cold} <= 2'h3;
    start_cmd_i <= 1;
    wt(IDL, 1);
    chk(running_o, 1'b1);
    cold <= 0;
    wt(IDL, 0);
  endtask : t_temp_mode

  task t_temp_hold();
    rst();
    wr(8'h00, 32'h000);
    fb_en <= 1;
    temp_hold_i <= 1;
    wt(REQ, 1);
    wt(RUN, 1);
    stop_cmd_i <= 1;
    repeat (40) @(posedge clk_i);
    chk(run_request_o, 1'b1);
    temp_hold_i <= 0;
    wt(REQ, 0);
  endtask : t_temp_hold

  // Main sequence.
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    t_regs();
    t_pickup();
    t_noteeth();
    t_oil();
    t_remove();
    t_idle_tmr();
    t_low_speed();
    t_temp_mode();
    t_temp_hold();
    conclude();
  end
endmodule : testbench
